// *** src/dio_pkg.sv ***
// Constants shared by the parallel port codeword receiver.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
package dio_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_STROBE_CFG = 8'h00;
	localparam logic [7:0] OFF_CW_CFG = 8'h04;
	localparam logic [7:0] OFF_HIGH_BITS = 8'h08;
	localparam logic [7:0] OFF_LOW_BITS = 8'h0C;
	localparam logic [7:0] OFF_CODEWORD = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	// ==========================================================
	// Field positions
	localparam int STROBE_IDX_LSB = 0;
	localparam int STROBE_EDGE_LSB = 8;
	localparam int VALID_IDX_LSB = 16;
	localparam int VALID_POL_LSB = 24;
	localparam int CW_MASK_LSB = 0;
	localparam int CW_SHIFT_LSB = 16;
	localparam int CW_VALID_BIT = 31;
	localparam int IRQ_STROBE_BIT = 0;
	localparam int IRQ_CODEWORD_BIT = 1;
	localparam int IRQ_TERR_BIT = 2;
	localparam int IRQ_BITS = 3;
	// ==========================================================
	// Setting encodings
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] POL_NONE = 2'h0;
	localparam logic [1:0] POL_LOW = 2'h1;
	localparam logic [1:0] POL_HIGH = 2'h2;
	localparam logic [1:0] POL_BOTH = 2'h3;
	// ==========================================================
	// Reset values
	localparam logic [3:0] RST_STROBE_IDX = 4'h0;
	localparam logic [3:0] RST_VALID_IDX = 4'h1;
	localparam logic [1:0] RST_EDGE = 2'h0;
	localparam logic [1:0] RST_POL = 2'h0;
	localparam logic [9:0] RST_CW_MASK = 10'h3FF;
	localparam logic [4:0] RST_CW_SHIFT = 5'h00;
	// ==========================================================
	// Timing: input synchroniser depth
	localparam int SYNC_STAGES = 3;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** src/port_sync.sv ***
// Three-stage synchroniser with agreement filter for a bus of pins.
// Assumes asynchronous inputs; each bit settles independently.
`timescale 1ns/1ps
module port_sync import dio_pkg::*; #(
	parameter int WIDTH = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] settled
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] agree;

	// Only the second and third stages are compared; the first is left alone
	assign agree = ~(s2 ^ s3);

	// Shift chain, then take each bit once two late stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			s2 <= '0;
			s3 <= '0;
			settled <= '0;
		end else begin
			meta <= pins;
			s2 <= meta;
			s3 <= s2;
			settled <= (settled & ~agree) | (s3 & agree);
		end
	end
endmodule

// *** src/dio_codeword_receiver.sv ***
// Parallel port codeword receiver: strobe/valid qualification, codeword
// extraction, level reports, timing error, AXI4-Lite registers and irq.
// Assumes port pins are asynchronous to aclk and far slower than it.
//
// Functional notes
// - Valid qualifier is any port bit 16 through 31, chosen by index.
// - Valid polarity none, low, high or both decides acceptance.
// - Port state is shifted by 0 to 31 positions before extraction.
// - Shifted state AND 10-bit mask forms the codeword.
// - Codeword selects the waveform for play-by-codeword; this block only drives it out on codeword with codeword_strobe.
// - 32-bit status word marks port bits currently high.
// - 32-bit status word marks port bits currently low.
// - Timing error when valid or data bits change with the strobe.
// - Strobe edge both accepts rising or falling strobe transitions.
// - Strobe input is any port bit 16 through 31, chosen by index.
// - Strobe edge none disables, rise and fall react to one edge.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dio_codeword_receiver import dio_pkg::*; #(
	parameter int PORT_W = 32,
	parameter int CW_W = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [PORT_W-1:0] parallel_io_port,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [CW_W-1:0] codeword,
	output logic codeword_strobe,
	output logic wait_port_strobe,
	output logic timing_error,
	output logic irq
);
	// ==========================================================
	// Port sampling
	logic [PORT_W-1:0] port_q;
	logic [PORT_W-1:0] port_p;

	port_sync #(.WIDTH(PORT_W)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins(parallel_io_port),
		.settled(port_q)
	);

	// Previous settled sample, for edge and change detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_p <= '0;
		end else begin
			port_p <= port_q;
		end
	end

	// ==========================================================
	// Configuration registers
	logic [3:0] strobe_idx;
	logic [1:0] strobe_edge;
	logic [3:0] valid_idx;
	logic [1:0] valid_pol;
	logic [CW_W-1:0] cw_mask;
	logic [4:0] cw_shift;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [31:0] high_bits;
	logic [31:0] low_bits;
	logic cw_seen;

	// ==========================================================
	// Strobe and valid selection
	// Only four index bits are stored, so selections outside 16..31 cannot exist.
	// strobe bit select
	wire [4:0] strobe_sel = {1'b1, strobe_idx};
	wire [4:0] valid_sel = {1'b1, valid_idx};
	wire strobe_now = port_q[strobe_sel];
	wire strobe_prev = port_p[strobe_sel];
	wire valid_now = port_q[valid_sel];
	wire valid_prev = port_p[valid_sel];
	wire strobe_rise = strobe_now & ~strobe_prev;
	wire strobe_fall = ~strobe_now & strobe_prev;

	wire strobe_event = (strobe_edge == EDGE_RISE && strobe_rise)
		|| (strobe_edge == EDGE_FALL && strobe_fall)
		|| (strobe_edge == EDGE_BOTH && (strobe_rise || strobe_fall));

	// valid polarity check; none and both accept either level
	wire valid_ok = (valid_pol == POL_NONE) || (valid_pol == POL_BOTH)
		|| (valid_pol == POL_LOW && !valid_now)
		|| (valid_pol == POL_HIGH && valid_now);
	wire cw_event = strobe_event && valid_ok;

	// ==========================================================
	// Codeword extraction
	// right shift toward bit zero
	wire [PORT_W-1:0] shifted = port_q >> cw_shift;
	wire [CW_W-1:0] cw_calc = shifted[CW_W-1:0] & cw_mask;

	// ==========================================================
	// Timing error: data bits are those the mask and shift select
	// The strobe bit is never counted as data, even when the field covers it,
	// otherwise every strobe edge would flag itself as a timing error
	wire [PORT_W-1:0] data_sel = PORT_W'({{(PORT_W-CW_W){1'b0}}, cw_mask} << cw_shift)
		& ~(PORT_W'(1) << strobe_sel);
	wire data_chg = |((port_q ^ port_p) & data_sel);
	wire valid_chg = (valid_pol != POL_NONE) && (valid_now != valid_prev);
	// change coincident with strobe; the controller is expected to avoid it
	wire terr_event = (strobe_edge != EDGE_NONE) && (strobe_now != strobe_prev)
		&& (data_chg || valid_chg);

	// Outputs toward the sequencer, all from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			codeword <= '0;
			codeword_strobe <= 1'b0;
			wait_port_strobe <= 1'b0;
			timing_error <= 1'b0;
			cw_seen <= 1'b0;
		end else begin
			if (cw_event) begin
				codeword <= cw_calc;
				cw_seen <= 1'b1;
			end
			codeword_strobe <= cw_event;
			wait_port_strobe <= strobe_event;
			timing_error <= terr_event;
		end
	end

	// Level reports, one cycle behind the settled sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_bits <= '0;
			low_bits <= '1;
		end else begin
			high_bits <= port_q;
			low_bits <= ~port_q;
		end
	end

	// ==========================================================
	// Interrupts: set wins over a write-one clear in the same cycle
	wire [IRQ_BITS-1:0] irq_set = {terr_event, cw_event, strobe_event};
	logic [IRQ_BITS-1:0] irq_clr;
	assign irq = |(irq_status & irq_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire [31:0] be = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire wr_strobe_cfg = do_write && wr_addr == OFF_STROBE_CFG;
	wire wr_cw_cfg = do_write && wr_addr == OFF_CW_CFG;
	wire wr_status = do_write && wr_addr == OFF_IRQ_STATUS;
	wire wr_mask = do_write && wr_addr == OFF_IRQ_MASK;
	wire wr_ro = do_write && (wr_addr == OFF_HIGH_BITS || wr_addr == OFF_LOW_BITS
		|| wr_addr == OFF_CODEWORD);
	wire wr_hit = wr_strobe_cfg || wr_cw_cfg || wr_status || wr_mask || wr_ro;
	wire [31:0] strobe_cfg_rd = {6'h00, valid_pol, 4'h0, valid_idx, 6'h00, strobe_edge,
		4'h0, strobe_idx};
	wire [31:0] cw_cfg_rd = {11'h000, cw_shift, 6'h00, cw_mask};
	wire [31:0] strobe_cfg_nx = (strobe_cfg_rd & ~be) | (wr_data & be);
	wire [31:0] cw_cfg_nx = (cw_cfg_rd & ~be) | (wr_data & be);
	assign irq_clr = wr_status ? (wr_data[IRQ_BITS-1:0] & be[IRQ_BITS-1:0]) : '0;

	// Handshake tracking and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_idx <= RST_STROBE_IDX;
			strobe_edge <= RST_EDGE;
			valid_idx <= RST_VALID_IDX;
			valid_pol <= RST_POL;
			cw_mask <= RST_CW_MASK;
			cw_shift <= RST_CW_SHIFT;
			irq_mask <= '0;
		end else begin
			if (wr_strobe_cfg) begin
				strobe_idx <= strobe_cfg_nx[STROBE_IDX_LSB +: 4];
				strobe_edge <= strobe_cfg_nx[STROBE_EDGE_LSB +: 2];
				valid_idx <= strobe_cfg_nx[VALID_IDX_LSB +: 4];
				valid_pol <= strobe_cfg_nx[VALID_POL_LSB +: 2];
			end
			if (wr_cw_cfg) begin
				cw_mask <= cw_cfg_nx[CW_MASK_LSB +: CW_W];
				cw_shift <= cw_cfg_nx[CW_SHIFT_LSB +: 5];
			end
			if (wr_mask) begin
				irq_mask <= (irq_mask & ~be[IRQ_BITS-1:0]) | (wr_data[IRQ_BITS-1:0]
					& be[IRQ_BITS-1:0]);
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path: one read at a time, data one cycle after address
	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
	wire [31:0] cw_rd = {cw_seen, {(31-CW_W){1'b0}}, codeword};
	assign s_axi_arready = !s_axi_rvalid;
	logic [31:0] next_rdata;
	logic next_rhit;
	always_comb begin
		next_rdata = 32'h00000000;
		next_rhit = 1'b1;
		if (rd_addr == OFF_STROBE_CFG) begin
			next_rdata = strobe_cfg_rd;
		end else if (rd_addr == OFF_CW_CFG) begin
			next_rdata = cw_cfg_rd;
		end else if (rd_addr == OFF_HIGH_BITS) begin
			next_rdata = high_bits;
		end else if (rd_addr == OFF_LOW_BITS) begin
			next_rdata = low_bits;
		end else if (rd_addr == OFF_CODEWORD) begin
			next_rdata = cw_rd;
		end else if (rd_addr == OFF_IRQ_STATUS) begin
			next_rdata = {{(32-IRQ_BITS){1'b0}}, irq_status};
		end else if (rd_addr == OFF_IRQ_MASK) begin
			next_rdata = {{(32-IRQ_BITS){1'b0}}, irq_mask};
		end else begin
			next_rhit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rhit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_strobe_index: assert property (strobe_edge == EDGE_RISE
		&& port_q[{1'b1, strobe_idx}] && !port_p[{1'b1, strobe_idx}] |=> wait_port_strobe)
		else $error("rising edge on selected strobe bit missed");
	a_valid_index: assert property ((valid_pol == POL_LOW && port_q[{1'b1, valid_idx}])
		|=> !codeword_strobe)
		else $error("codeword accepted with selected valid bit high under low polarity");
	a_valid_gate: assert property ((valid_pol == POL_HIGH && !valid_now) |=> !codeword_strobe)
		else $error("codeword accepted with valid low under high polarity");
	a_cw_extract: assert property (cw_event |=> codeword == $past(cw_calc) && codeword_strobe)
		else $error("codeword not captured from shifted and masked state");
	a_shift_right: assert property (cw_shift == 5'd0 |-> cw_calc == (port_q[CW_W-1:0] & cw_mask))
		else $error("zero shift does not pass low bits");
	a_levels_pair: assert property (1'b1 |=> low_bits == ~$past(port_q))
		else $error("low bits not the inverse of the port");
	a_high_track: assert property ($changed(port_q) |=> high_bits == $past(port_q))
		else $error("high bits not following port");
	a_timing_err: assert property ((strobe_edge != EDGE_NONE && strobe_now != strobe_prev
		&& data_chg) |=> timing_error)
		else $error("coincident data change not flagged");
	a_both_edge: assert property ((strobe_edge == EDGE_BOTH && strobe_fall) |=> wait_port_strobe)
		else $error("falling strobe ignored under both");
	a_edge_none: assert property (strobe_edge == EDGE_NONE |=> !wait_port_strobe)
		else $error("strobe fired while disabled");
	a_irq_level: assert property ((|(irq_set & irq_mask)) && !wr_mask |=> irq)
		else $error("unmasked event did not raise irq");

	c_codeword: cover property (cw_event ##1 codeword_strobe);
	c_terr: cover property (timing_error);
	c_both: cover property (strobe_edge == EDGE_BOTH && strobe_fall);
	c_irq: cover property ($rose(irq));
endmodule

// *** sim/port_ctrl.sv ***
// Behavioural model of the controller that drives the port pins.
// Assumes the bench raises go for one cycle per transfer, with
// word already holding the final pin state, strobe bit included.
`timescale 1ns/1ps
module port_ctrl (
	input wire logic go,
	input wire logic skew,
	input wire logic [3:0] sidx,
	input wire logic [31:0] word,
	output logic [31:0] pins
);
	// ==========================================
	// Transfer
	// Offset keeps pin changes away from clock edges; one process owns the pins
	initial begin
		pins = 32'h0000_0000;
		forever begin
			@(posedge go);
			#3;
			if (!skew) begin
				pins = word;
				pins[{1'b1, sidx}] = !word[{1'b1, sidx}];
				#40;
			end
			pins = word;
		end
	end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the parallel port codeword receiver.
// Assumes the controller model port_ctrl on the port pins.
`timescale 1ns/1ps
module tb import dio_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, skew = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, word = 32'h0000_0000, pv = 32'h0000_0000;
	logic [31:0] pins, rdata;
	logic awready, wready, bvalid, arready, rvalid, cw_stb, ws, te, irq;
	logic [1:0] bresp, rresp, edg, pol;
	logic [9:0] codeword, mask, last_cw;
	logic [4:0] shift;
	logic [3:0] sidx = 4'h0, vidx;
	logic [3:0] wstrb = 4'hF;
	logic [9:0] cw_q[$];
	logic [33:0] rd_q[$];
	int err_count = 0, tests_run = 0, ws_n = 0, ws_exp = 0, te_n = 0, seed;

	// ==========================================
	// Clock and instances
	initial forever #4 aclk = !aclk;
	dio_codeword_receiver dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.parallel_io_port(pins),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.codeword(codeword),
		.codeword_strobe(cw_stb),
		.wait_port_strobe(ws),
		.timing_error(te),
		.irq(irq)
	);
	port_ctrl ctrl (
		.go(go),
		.skew(skew),
		.sidx(sidx),
		.word(word),
		.pins(pins)
	);

	// ==========================================
	// Checking and closing
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================
	// Bus tasks: each channel held until its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk("bresp", 34'(r), 34'(bresp));
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rd_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// ==========================================
	// Port tasks
	task automatic cfg(input logic [1:0] e, input logic [1:0] p, input logic [4:0] sh,
		input logic [9:0] m);
		edg = e;
		pol = p;
		shift = sh;
		mask = m;
		sidx = 4'($urandom);
		vidx = sidx + 4'(1 + $urandom % 15);
		wr(OFF_STROBE_CFG, {6'h00, p, 4'h0, vidx, 6'h00, e, 4'h0, sidx}, RESP_OKAY);
		wr(OFF_CW_CFG, {11'h000, sh, 6'h00, m}, RESP_OKAY);
	endtask
	// Skew moves masked data with the strobe; used with shift 0 only
	task automatic xfer(input logic sk);
		logic [31:0] w;
		logic hit;
		logic ok;
		w = sk ? pv ^ {22'h00000, mask} : 32'($urandom);
		w[{1'b1, sidx}] = !pv[{1'b1, sidx}];
		hit = edg == EDGE_BOTH || (edg == EDGE_RISE && w[{1'b1, sidx}]);
		hit = hit || (edg == EDGE_FALL && !w[{1'b1, sidx}]);
		ok = pol == POL_NONE || pol == POL_BOTH || (pol == POL_HIGH) == w[{1'b1, vidx}];
		ws_exp += int'(hit);
		if (hit && ok) begin
			last_cw = 10'(w >> shift) & mask;
			cw_q.push_back(last_cw);
		end
		word <= w;
		skew <= sk;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (12) @(posedge aclk);
		pv = w;
	endtask

	// ==========================================
	// Result watcher: each result takes the oldest note
	always @(posedge aclk) begin
		if (cw_stb === 1'b1) begin
			chk("codeword", cw_q.size() ? 34'(cw_q.pop_front()) : 34'h3_0000_0000,
				34'(codeword));
		end
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk("rdata", rd_q.size() ? rd_q.pop_front() : 34'h3_FFFF_FFFF,
				{rresp, rdata});
		end
		ws_n += int'(ws === 1'b1);
		te_n += int'(te === 1'b1);
	end

	// Watchdog: the sequence takes about 750 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		end_sim();
	end

	// ==========================================
	// Main sequence
	initial begin
		seed = $urandom(35);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_STROBE_CFG, {RESP_OKAY, 32'h0001_0000});
		rd(OFF_CW_CFG, {RESP_OKAY, 32'h0000_03FF});
		rd(OFF_LOW_BITS, {RESP_OKAY, 32'hFFFF_FFFF});
		rd(8'h1C, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(OFF_HIGH_BITS, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFF_HIGH_BITS, {RESP_OKAY, 32'h0000_0000});
		// Byte strobes: only the low byte of the mask field may change
		wstrb <= 4'h1;
		wr(OFF_CW_CFG, 32'h001F_0000, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFF_CW_CFG, {RESP_OKAY, 32'h0000_0300});
		// Every edge and polarity mode, random shift and mask
		for (int e = 0; e < 4; e++) begin
			for (int p = 0; p < 4; p++) begin
				cfg(2'(e), 2'(p), 5'($urandom), 10'($urandom));
				xfer(1'b0);
				xfer(1'b0);
				rd(OFF_HIGH_BITS, {RESP_OKAY, pv});
				rd(OFF_LOW_BITS, {RESP_OKAY, ~pv});
			end
		end
		// Data settles well before the strobe above, so no timing error may appear
		chk("terr", 34'h0, 34'(te_n));
		// Interrupt raise, mask and clear
		cfg(EDGE_BOTH, POL_NONE, 5'h00, 10'h3FF);
		wr(OFF_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
		rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0000_0000});
		wr(OFF_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
		chk("irq", 34'h0, 34'(irq));
		xfer(1'b0);
		chk("irq", 34'h1, 34'(irq));
		rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0000_0003});
		wr(OFF_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
		chk("irq", 34'h0, 34'(irq));
		wr(OFF_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
		wr(OFF_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
		chk("irq", 34'h0, 34'(irq));
		rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0000_0001});
		// Data moving in the same sample as the strobe
		te_n = 0;
		xfer(1'b1);
		chk("terr", 34'h1, 34'(te_n));
		rd(OFF_IRQ_STATUS, {RESP_OKAY, 32'h0000_0007});
		rd(OFF_CODEWORD, {RESP_OKAY, 1'b1, 21'h00000, last_cw});
		chk("strobes", 34'(ws_exp), 34'(ws_n));
		chk("pending", 34'h0, 34'(cw_q.size()));
		end_sim();
	end
endmodule
